// [verilog/adc_out_pkg.sv]
package adc_out_pkg;

  // ---------------------------------------------------------------
  // Widths and codes
  // ---------------------------------------------------------------
  localparam int           WORD_W      = 12;
  localparam int           IN_W        = 13;
  localparam int           DIFF_W      = 14;
  localparam int           LATENCY     = 11;
  localparam int           PTR_W       = 4;
  localparam logic [11:0]  CODE_MAX    = 12'hfff;
  localparam logic [11:0]  CODE_MIN    = 12'h000;
  localparam logic [11:0]  MSB_FLIP    = 12'h800;
  localparam logic [13:0]  MID_OFFSET  = 14'h0800;
  localparam logic [13:0]  POS_LIMIT   = 14'h07ff;
  localparam logic [13:0]  NEG_LIMIT   = 14'h3800;
  localparam logic [3:0]   PTR_LAST    = 4'ha;
  localparam logic [3:0]   FILL_FULL   = 4'hb;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int           CLK_MHZ          = 100;
  localparam int           SAMPLE_MIN_MHZ   = 20;
  localparam int           GAP_MAX_CYCLES   = CLK_MHZ / SAMPLE_MIN_MHZ;
  localparam logic [7:0]   GAP_MAX          = 8'(GAP_MAX_CYCLES);

  typedef struct packed {
    logic        ovr;
    logic [11:0] code;
  } word_s;

endpackage : adc_out_pkg

// [verilog/adc_delay_mem.sv]
`timescale 1ns/100ps
`default_nettype none
module adc_delay_mem
  import adc_out_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Write side
  input  wire logic              wr_en,
  input  wire logic [PTR_W-1:0]  addr,
  input  wire word_s             wr_data,
  // Read side
  output word_s                  rd_data
);

  word_s mem [0:LATENCY-1];

  // ---------------------------------------------------------------
  // Read-before-write: the slot returns the word stored one lap ago.
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (wr_en) begin
      rd_data   <= mem[addr];
      mem[addr] <= wr_data;
    end
  end

endmodule : adc_delay_mem
`default_nettype wire

// [verilog/adc_out_core.sv]
// Notes on behaviour
// - Sample input on every sampling clock rise.
// - Divided mode samples every second rise only.
// - Divide select low halves rate, high disables.
// - Undriven divide select reads low, dividing.
// - Word appears eleven samples after capture.
// - Twelve-bit word, each bit as true/complement pair.
// - Format select low two's complement, high offset.
// - Undriven format select gives two's complement.
// - Over-range pair flags beyond either full scale.
// - Offset binary full scale and midscale codes.
// - Two's complement full scale and midscale codes.
// - Beyond range clamps to full scale code.
// - Duty equalizer always on; clock above 20MHz.
// - Forward a differential data clock with words.
`timescale 1ns/100ps
`default_nettype none
module adc_out_core
  import adc_out_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_B,
  // Sampling clock pins
  input  wire logic              SAMPLE_CLOCK_TRUE,
  input  wire logic              SAMPLE_CLOCK_COMP,
  // Quantised analog inputs
  input  wire logic [IN_W-1:0]   ANALOG_IN_POS,
  input  wire logic [IN_W-1:0]   ANALOG_IN_NEG,
  // Static configuration pins
  input  wire logic              HALF_RATE_SELECT,
  input  wire logic              HALF_RATE_SELECT_DRIVEN,
  input  wire logic              FORMAT_SELECT,
  input  wire logic              FORMAT_SELECT_DRIVEN,
  // Output word pairs
  output logic [WORD_W-1:0]      SAMPLE_WORD_TRUE,
  output logic [WORD_W-1:0]      SAMPLE_WORD_COMP,
  output logic                   OVER_RANGE_TRUE,
  output logic                   OVER_RANGE_COMP,
  // Forwarded data clock and status
  output logic                   DATA_CLOCK_OUT_TRUE,
  output logic                   DATA_CLOCK_OUT_COMP,
  output logic                   CLOCK_TOO_SLOW
);

  // ---------------------------------------------------------------
  // Encoding
  // ---------------------------------------------------------------
  function automatic word_s encode(input logic [DIFF_W-1:0] diff, input logic offset_bin);
    word_s w;
    logic [DIFF_W-1:0] biased;
    w      = '0;
    biased = diff + MID_OFFSET;
    if (!diff[DIFF_W-1] && diff > POS_LIMIT) begin
      w.ovr  = 1'b1;
      w.code = CODE_MAX;
    end else if (diff[DIFF_W-1] && diff < NEG_LIMIT) begin
      w.ovr  = 1'b1;
      w.code = CODE_MIN;
    end else begin
      w.code = biased[WORD_W-1:0];
    end
    if (!offset_bin) begin
      w.code = w.code ^ MSB_FLIP;
    end
    return w;
  endfunction : encode

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0]        clkt_s, sample_clock_comp_s, hrs_s, hrd_s, fs_s, fsd_s;
  logic [IN_W-1:0]   pos_s1, pos_s2, neg_s1, neg_s2;
  logic              clk_hi_r;

  always_ff @(posedge CLK) begin
    clkt_s <= {clkt_s[0], SAMPLE_CLOCK_TRUE};
    sample_clock_comp_s <= {sample_clock_comp_s[0], SAMPLE_CLOCK_COMP};
    hrs_s  <= {hrs_s[0], HALF_RATE_SELECT};
    hrd_s  <= {hrd_s[0], HALF_RATE_SELECT_DRIVEN};
    fs_s   <= {fs_s[0], FORMAT_SELECT};
    fsd_s  <= {fsd_s[0], FORMAT_SELECT_DRIVEN};
    pos_s1 <= ANALOG_IN_POS;
    pos_s2 <= pos_s1;
    neg_s1 <= ANALOG_IN_NEG;
    neg_s2 <= neg_s1;
  end

  // Only the rising transition matters, so the input duty cycle is irrelevant.
  logic clk_hi;
  logic clk_rise;
  assign clk_hi   = clkt_s[1] & ~sample_clock_comp_s[1];
  assign clk_rise = clk_hi & ~clk_hi_r;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      // Reset as if already high, so a pin left high gives no false rise.
      clk_hi_r <= 1'b1;
    end else begin
      clk_hi_r <= clk_hi;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode: an undriven pin reads as its pull-down level
  // ---------------------------------------------------------------
  logic div_mode;
  logic offset_bin;
  assign div_mode   = ~(hrd_s[1] & hrs_s[1]);
  assign offset_bin = fsd_s[1] & fs_s[1];

  // ---------------------------------------------------------------
  // Sample strobe and divide phase
  // ---------------------------------------------------------------
  logic phase_r;
  logic strobe;
  assign strobe = clk_rise & (~div_mode | ~phase_r);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      phase_r <= 1'b0;
    end else if (!div_mode) begin
      phase_r <= 1'b0;
    end else if (clk_rise) begin
      phase_r <= ~phase_r;
    end
  end

  // ---------------------------------------------------------------
  // Clock rate watch
  // ---------------------------------------------------------------
  logic [7:0] gap_r;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      gap_r          <= 8'h00;
      CLOCK_TOO_SLOW <= 1'b0;
    end else if (clk_rise) begin
      gap_r          <= 8'h00;
      CLOCK_TOO_SLOW <= 1'b0;
    end else begin
      if (gap_r != 8'hff) begin
        gap_r <= gap_r + 8'h01;
      end
      if (gap_r >= GAP_MAX) begin
        CLOCK_TOO_SLOW <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pipeline latency
  // ---------------------------------------------------------------
  logic [PTR_W-1:0]  ptr_r;
  logic [3:0]        fill_r;
  logic              rd_valid_r;
  word_s             enc_word;
  word_s             late_word;
  assign enc_word = encode(DIFF_W'({1'b0, pos_s2} - {1'b0, neg_s2}), offset_bin);

  adc_delay_mem u_mem (
    .clk     (CLK),
    .wr_en   (strobe),
    .addr    (ptr_r),
    .wr_data (enc_word),
    .rd_data (late_word)
  );

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ptr_r      <= '0;
      fill_r     <= 4'h0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= strobe && fill_r == FILL_FULL;
      if (strobe) begin
        ptr_r <= (ptr_r == PTR_LAST) ? '0 : ptr_r + 4'h1;
        if (fill_r != FILL_FULL) begin
          fill_r <= fill_r + 4'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Output word and data clock
  // ---------------------------------------------------------------
  logic upd_r;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      SAMPLE_WORD_TRUE <= '0;
      SAMPLE_WORD_COMP <= '1;
      OVER_RANGE_TRUE  <= 1'b0;
      OVER_RANGE_COMP  <= 1'b1;
      upd_r            <= 1'b0;
    end else begin
      upd_r <= rd_valid_r;
      if (rd_valid_r) begin
        SAMPLE_WORD_TRUE <= late_word.code;
        SAMPLE_WORD_COMP <= ~late_word.code;
        OVER_RANGE_TRUE  <= late_word.ovr;
        OVER_RANGE_COMP  <= ~late_word.ovr;
      end
    end
  end

  // The rise follows each word update, ready for the receiver to latch.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      DATA_CLOCK_OUT_TRUE <= 1'b0;
      DATA_CLOCK_OUT_COMP <= 1'b1;
    end else if (upd_r) begin
      DATA_CLOCK_OUT_TRUE <= 1'b1;
      DATA_CLOCK_OUT_COMP <= 1'b0;
    end else if (rd_valid_r) begin
      DATA_CLOCK_OUT_TRUE <= 1'b0;
      DATA_CLOCK_OUT_COMP <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_sample_every_rise: assert property (@(posedge CLK) disable iff (!RST_B)
    clk_rise && !div_mode |-> strobe) else $error("rise not sampled");
  a_div_skip_rise: assert property (@(posedge CLK) disable iff (!RST_B)
    clk_rise && div_mode && phase_r |-> !strobe) else $error("divided mode sampled twice");
  a_div_select_high: assert property (@(posedge CLK) disable iff (!RST_B)
    hrd_s[1] && hrs_s[1] && clk_rise |-> strobe) else $error("undivided rise lost");
  a_div_default_on: assert property (@(posedge CLK) disable iff (!RST_B)
    !hrd_s[1] && clk_rise && phase_r |-> !strobe) else $error("undriven select not dividing");
  a_latency_update: assert property (@(posedge CLK) disable iff (!RST_B)
    strobe && fill_r == FILL_FULL |-> ##2 upd_r ##1 DATA_CLOCK_OUT_TRUE)
    else $error("word update timing wrong");
  a_word_pairs: assert property (@(posedge CLK) disable iff (!RST_B)
    SAMPLE_WORD_COMP == ~SAMPLE_WORD_TRUE) else $error("word pair mismatch");
  a_range_pair: assert property (@(posedge CLK) disable iff (!RST_B)
    OVER_RANGE_COMP == !OVER_RANGE_TRUE) else $error("range pair mismatch");
  a_offset_clamp: assert property (@(posedge CLK) disable iff (!RST_B)
    offset_bin && enc_word.ovr |-> enc_word.code == CODE_MAX || enc_word.code == CODE_MIN)
    else $error("offset clamp wrong");
  a_twos_clamp: assert property (@(posedge CLK) disable iff (!RST_B)
    !offset_bin && enc_word.ovr |->
    enc_word.code == (enc_word.code[11] ? (CODE_MIN ^ MSB_FLIP) : (CODE_MAX ^ MSB_FLIP)))
    else $error("twos clamp wrong");
  a_data_clock_rise: assert property (@(posedge CLK) disable iff (!RST_B)
    rd_valid_r |=> !DATA_CLOCK_OUT_TRUE || $past(upd_r) ##1 DATA_CLOCK_OUT_TRUE)
    else $error("data clock missing rise");

endmodule : adc_out_core
`default_nettype wire

// [bench/word_receiver.sv]
`timescale 1ns/100ps
`default_nettype none
module word_receiver
  import adc_out_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Pins from the converter
  input  wire logic [WORD_W-1:0] word_true,
  input  wire logic [WORD_W-1:0] word_comp,
  input  wire logic              ovr_true,
  input  wire logic              ovr_comp,
  input  wire logic              dclk_true,
  input  wire logic              dclk_comp,
  // Captured words
  output logic                   cap_pulse,
  output word_s                  cap_word,
  output logic                   pair_ok
);
  // ---------------------------------------------------------------
  // Latch on the rise of the forwarded data clock
  // ---------------------------------------------------------------
  logic dclk_r;

  always_ff @(posedge clk) begin
    dclk_r    <= dclk_true;
    cap_pulse <= dclk_true & ~dclk_r;
    if (dclk_true && !dclk_r) begin
      cap_word <= '{ovr: ovr_true, code: word_true};
      pair_ok  <= (word_comp === ~word_true) && (ovr_comp === ~ovr_true) &&
                  (dclk_comp === ~dclk_true);
    end
  end
endmodule : word_receiver
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb;
  import adc_out_pkg::*;
  logic CLK, RST_B, SCT, SCC, HRS, HRSD, FS, FSD;
  logic [IN_W-1:0]   AIP, AIN;
  logic [WORD_W-1:0] WT, WC;
  logic OT, OC, DT, DC, SLOW, cap_pulse, pair_ok;
  word_s cap_word;
  word_s exp_q[$];
  word_s exp_w;
  int err_count, comparisons, got_n;
  int vals[5] = '{2047, -2048, 0, 3000, -3000};

  adc_out_core u_adc_out_core (.CLK(CLK), .RST_B(RST_B), .SAMPLE_CLOCK_TRUE(SCT),
    .SAMPLE_CLOCK_COMP(SCC), .ANALOG_IN_POS(AIP), .ANALOG_IN_NEG(AIN),
    .HALF_RATE_SELECT(HRS), .HALF_RATE_SELECT_DRIVEN(HRSD), .FORMAT_SELECT(FS),
    .FORMAT_SELECT_DRIVEN(FSD), .SAMPLE_WORD_TRUE(WT), .SAMPLE_WORD_COMP(WC),
    .OVER_RANGE_TRUE(OT), .OVER_RANGE_COMP(OC), .DATA_CLOCK_OUT_TRUE(DT),
    .DATA_CLOCK_OUT_COMP(DC), .CLOCK_TOO_SLOW(SLOW));
  word_receiver u_word_receiver (.clk(CLK), .word_true(WT), .word_comp(WC), .ovr_true(OT),
    .ovr_comp(OC), .dclk_true(DT), .dclk_comp(DC), .cap_pulse(cap_pulse),
    .cap_word(cap_word), .pair_ok(pair_ok));

  // ---------------------------------------------------------------
  // Clock, watchdog and expected codes
  // ---------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  initial begin
    #50us;
    err_count++;
    finish_test();
  end

  function automatic word_s expect_w(int d, bit ofs);
    word_s w;
    w.ovr = (d > 2047) || (d < -2048);
    w.code = (d > 2047) ? 12'hfff : (d < -2048) ? 12'h000 : 12'(d + 2048);
    if (!ofs) w.code = w.code ^ 12'h800;
    return w;
  endfunction : expect_w

  // Every captured word is judged against the oldest outstanding sample.
  always @(negedge CLK) begin
    if (cap_pulse === 1'b1) begin
      got_n++;
      `CHK("pairs", 1'b1, pair_ok)
      if (exp_q.size() == 0) begin
        `CHK("extra", 1'b0, 1'b1)
      end else begin
        exp_w = exp_q.pop_front();
        `CHK("word", exp_w, cap_word)
      end
    end
  end

  // ---------------------------------------------------------------
  // Drivers and scenarios
  // ---------------------------------------------------------------
  task automatic strobe(int d);
    @(negedge CLK);
    SCT <= 1'b0;
    SCC <= 1'b1;
    AIP <= 13'(4096 + d);
    repeat (2) @(negedge CLK);
    SCT <= 1'b1;
    SCC <= 1'b0;
    @(negedge CLK);
  endtask : strobe

  task automatic run_cfg(string nm, logic fs, logic fsd, logic hs, logic hsd, bit ofs,
                         bit div);
    @(negedge CLK);
    FS <= fs;
    FSD <= fsd;
    HRS <= hs;
    HRSD <= hsd;
    RST_B <= 1'b0;
    SCT <= 1'b0;
    SCC <= 1'b1;
    repeat (3) @(negedge CLK);
    RST_B <= 1'b1;
    repeat (3) @(negedge CLK);
    got_n = 0;
    for (int i = 0; i < 5; i++) begin
      exp_q.push_back(expect_w(vals[i], ofs));
      strobe(vals[i]);
      if (div) strobe(100);
    end
    repeat (div ? 22 : 11) strobe(0);
    repeat (20) @(negedge CLK);
    `CHK("count", 5, got_n)
    `CHK("slow", 1'b1, SLOW)
    exp_q.push_back(expect_w(0, ofs));
    strobe(0);
    repeat (5) @(negedge CLK);
    `CHK("slow_clr", 1'b0, SLOW)
    repeat (3) @(negedge CLK);
    `CHK("drain", 0, exp_q.size())
    exp_q.delete();
    $display("test %s done", nm);
  endtask : run_cfg

  task automatic test_twos_full();
    run_cfg("twos_full", 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
  endtask : test_twos_full

  task automatic test_offset_full();
    run_cfg("offset_full", 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
  endtask : test_offset_full

  task automatic test_offset_half();
    run_cfg("offset_half", 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
  endtask : test_offset_half

  task automatic test_open_pins();
    run_cfg("open_pins", 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
  endtask : test_open_pins

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  initial begin
    RST_B = 1'b0;
    SCT = 1'b0;
    SCC = 1'b1;
    AIP = 13'h1000;
    AIN = 13'h1000;
    HRS = 1'b1;
    HRSD = 1'b1;
    FS = 1'b0;
    FSD = 1'b1;
    repeat (20) @(negedge CLK);
    RST_B <= 1'b1;
    test_twos_full();
    test_offset_full();
    test_offset_half();
    test_open_pins();
    finish_test();
  end
endmodule : tb
`default_nettype wire
